// File: logic/ctci_pkg.sv
// ctci_pkg: register offsets, field positions, reset values and codes
// for the clock tree configuration and clock interrupt block.
// assumes a 32-bit ahb-lite slave decode on haddr[7:2].
package ctci_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, bits 7:0)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG0_OFFSET = 8'h04;  // clock_config_0
  localparam logic [7:0] INT_OFFSET  = 8'h08;  // clock_interrupt_ctrl
  localparam logic [7:0] CFG1_OFFSET = 8'h2C;  // clock_config_1 (pre-divider view)

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG0_RESET = 32'h00000000;
  localparam logic [31:0] INT_RESET  = 32'h00000000;
  localparam logic [3:0]  CFG1_PREDIV_RESET = 4'h0;

  // ----------------------------------------------------------------
  // clock_config_0 field positions
  // ----------------------------------------------------------------
  localparam int MF_HI_BIT    = 29;  // pll_mult_factor[4]
  localparam int ADC_HI_BIT   = 28;  // adc_clock_prescale[2]
  localparam int CKOUT_LSB    = 24;  // clock_out_source_sel[3:0]
  localparam int USB_LSB      = 22;  // usb_clock_prescale[1:0]
  localparam int MF_LO_LSB    = 18;  // pll_mult_factor[3:0]
  localparam int PREDIV_BIT   = 17;  // prediv0_low_bit
  localparam int PLL_SRC_BIT  = 16;  // pll_source_sel
  localparam int ADC_LO_LSB   = 14;  // adc_clock_prescale[1:0]
  localparam int APB2_LSB     = 11;  // apb2_prescale[2:0]
  localparam int APB1_LSB     = 8;   // apb1_prescale[2:0]
  localparam int AHB_LSB      = 4;   // ahb_prescale[3:0]
  localparam int STAT_LSB     = 2;   // sysclk_switch_status[1:0]
  localparam int REQ_LSB      = 0;   // sysclk_switch[1:0]

  // ----------------------------------------------------------------
  // clock_interrupt_ctrl field positions
  // ----------------------------------------------------------------
  localparam int INT_CLR_LSB  = 16;  // write-1 clear bits 23:16
  localparam int INT_EN_LSB   = 8;   // enables 14:8
  localparam int INT_FLAG_LSB = 0;   // flags 7:0
  localparam int STUCK_BIT    = 7;   // stuck_clock_flag
  localparam int N_OSC        = 7;   // stabilisation sources, flags 6:0

  // ----------------------------------------------------------------
  // system clock source codes, synchronised line count
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INT8M = 2'h0;
  localparam logic [1:0] SRC_XTAL  = 2'h1;
  localparam logic [1:0] SRC_PLL   = 2'h2;
  localparam int         N_ASYNC   = 10;  // synchronised input lines

  typedef enum logic {CTCI_BUS_IDLE, CTCI_BUS_RDWAIT} ctci_bus_state_t;

endpackage

// File: logic/ctci_top.sv
// ctci_top: clock tree configuration registers, system clock switch
// sequencing and clock interrupt flags behind an ahb-lite slave.
// assumes oscillator ready, crystal stuck, usb enable and wake inputs
// are asynchronous levels; divider and mux outputs feed analog/clock logic.
//
// How it works
// - clock-out selector decoded into mux code
// - usb prescale code gives pll divide ratio
// - usb prescale frozen while usb clock enabled
// - multiplier msb at bit 29, low 21:18
// - multiplier table incl 6.5 and 16
// - prediv0 low bit shared with config_1
// - low bit alone picks div2 or pass while config_1 upper bits clear
// - pll source: internal 8m osc/2 or crystal
// - adc prescale split field, table of divides
// - apb prescalers divide ahb clock
// - ahb prescale divides system clock
// - read-only switch status from hardware
// - switch request, software polls status
// - forced to internal osc on wake or failure
// - interrupt register at 0x08, byte lanes
// - write-one clear bits 23:16
// - enables 14:8 paired with flags
// - flag set on ready when enabled
// - stuck flag set, routed to nmi
// - switch waits until target source stable
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps

module ctci_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // asynchronous status from the oscillators and power control
  input  wire logic [6:0]  osc_stable_async,
  input  wire logic        xtal_stuck_async,
  input  wire logic        usb_clk_en_async,
  input  wire logic        wake_async,
  // clock tree controls
  output logic [1:0]       sysclk_mux_sel,
  output logic [3:0]       clock_out_mux_sel,
  output logic [2:0]       usb_div_x2,
  output logic [6:0]       pll_mult_x2,
  output logic             pll_source_sel,
  output logic [4:0]       prediv0_div,
  output logic [4:0]       adc_div,
  output logic [4:0]       apb2_div,
  output logic [4:0]       apb1_div,
  output logic [9:0]       ahb_div,
  output logic             clock_irq,
  output logic             clock_nmi
);

  // ----------------------------------------------------------------
  // decode tables
  // ----------------------------------------------------------------

  // multiplier times two, so 6.5 stays an integer; x32 needs seven bits
  function automatic logic [6:0] mult_x2(input logic [4:0] code);
    logic [6:0] m;
    m = 7'h00;
    if (code <= 5'h0C) begin
      m = 7'({2'b00, code} + 7'h02);
    end else if (code == 5'h0D) begin
      m = 7'h06;  // 6.5 expressed as half-steps below
    end else if (code == 5'h0E || code == 5'h0F) begin
      m = 7'h10;
    end else begin
      m = 7'({2'b00, code} + 7'h01);
    end
    if (code == 5'h0D) begin
      mult_x2 = 7'h0D;
    end else begin
      mult_x2 = 7'(m << 1);
    end
  endfunction

  // usb divide times two: 1.5, 1, 2.5, 2
  function automatic logic [2:0] usb_x2(input logic [1:0] code);
    case (code)
      2'h0:    usb_x2 = 3'h3;
      2'h1:    usb_x2 = 3'h2;
      2'h2:    usb_x2 = 3'h5;
      default: usb_x2 = 3'h4;
    endcase
  endfunction

  function automatic logic [4:0] adc_dec(input logic [2:0] code);
    case (code)
      3'h0:    adc_dec = 5'h02;
      3'h1:    adc_dec = 5'h04;
      3'h2:    adc_dec = 5'h06;
      3'h3:    adc_dec = 5'h08;
      3'h4:    adc_dec = 5'h02;
      3'h5:    adc_dec = 5'h0C;
      3'h6:    adc_dec = 5'h08;
      default: adc_dec = 5'h10;
    endcase
  endfunction

  // 0xx passes, 1xx divides by 2..16
  function automatic logic [4:0] apb_dec(input logic [2:0] code);
    if (!code[2]) begin
      apb_dec = 5'h01;
    end else begin
      apb_dec = 5'(5'h02 << code[1:0]);
    end
  endfunction

  function automatic logic [9:0] ahb_dec(input logic [3:0] code);
    case (code)
      4'h8:    ahb_dec = 10'h002;
      4'h9:    ahb_dec = 10'h004;
      4'hA:    ahb_dec = 10'h008;
      4'hB:    ahb_dec = 10'h010;
      4'hC:    ahb_dec = 10'h040;
      4'hD:    ahb_dec = 10'h080;
      4'hE:    ahb_dec = 10'h100;
      4'hF:    ahb_dec = 10'h200;
      default: ahb_dec = 10'h001;  // 0xxx passes undivided
    endcase
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [ctci_pkg::N_ASYNC-1:0] async_in;   // raw asynchronous lines
  logic [ctci_pkg::N_ASYNC-1:0] s1_reg;     // first stage, read by s2 only
  logic [ctci_pkg::N_ASYNC-1:0] s2_reg;
  logic [ctci_pkg::N_ASYNC-1:0] s3_reg;
  logic [ctci_pkg::N_ASYNC-1:0] lvl_reg;    // filtered level
  logic [ctci_pkg::N_ASYNC-1:0] lvl_next;
  logic [ctci_pkg::N_ASYNC-1:0] lvl_d_reg;  // previous level, for edges

  assign async_in = {wake_async, usb_clk_en_async, xtal_stuck_async, osc_stable_async};

  // a change counts only when stages two and three agree
  always_comb begin
    for (int i = 0; i < ctci_pkg::N_ASYNC; i++) begin
      lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      lvl_reg   <= '0;
      lvl_d_reg <= '0;
    end else begin
      s1_reg    <= async_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      lvl_reg   <= lvl_next;
      lvl_d_reg <= lvl_reg;
    end
  end

  logic [6:0] osc_ready;   // filtered ready levels, flag order
  logic [6:0] osc_rise;    // ready just became true
  logic       stuck_rise;  // crystal failure event
  logic       usb_on;      // usb clock running
  logic       wake_rise;   // leaving deep-sleep or standby

  assign osc_ready  = lvl_reg[6:0];
  assign osc_rise   = lvl_reg[6:0] & ~lvl_d_reg[6:0];
  assign stuck_rise = lvl_reg[7] & ~lvl_d_reg[7];
  assign usb_on     = lvl_reg[8];
  assign wake_rise  = lvl_reg[9] & ~lvl_d_reg[9];

  // ----------------------------------------------------------------
  // ahb-lite slave: zero-wait writes, one-wait reads
  // ----------------------------------------------------------------
  ctci_pkg::ctci_bus_state_t bus_state_reg, bus_state_next;
  logic        dp_write_reg, dp_write_next;  // write data phase pending
  logic [7:0]  dp_addr_reg,  dp_addr_next;   // latched byte address
  logic [3:0]  dp_be_reg,    dp_be_next;     // latched byte lanes
  logic [31:0] hrdata_reg,   hrdata_next;
  logic        hready_reg,   hready_next;
  logic        addr_take;                    // address phase accepted
  logic [3:0]  be_addr;                      // lanes of incoming request
  logic [31:0] rd_value;                     // read mux output

  assign addr_take = hsel & htrans[1] & hready;

  always_comb begin
    case (hsize)
      3'h0:    be_addr = 4'(4'h1 << haddr[1:0]);
      3'h1:    be_addr = haddr[1] ? 4'hC : 4'h3;
      default: be_addr = 4'hF;
    endcase
  end

  // reads wait one cycle so a write finishing at the same edge is seen
  always_comb begin
    bus_state_next = bus_state_reg;
    dp_write_next  = 1'b0;
    dp_addr_next   = dp_addr_reg;
    dp_be_next     = dp_be_reg;
    hrdata_next    = hrdata_reg;
    hready_next    = hready_reg;
    case (bus_state_reg)
      ctci_pkg::CTCI_BUS_IDLE: begin
        if (addr_take) begin
          dp_addr_next = {haddr[7:2], 2'b00};
          dp_be_next   = be_addr;
          if (hwrite) begin
            dp_write_next = 1'b1;
            hready_next   = 1'b1;
          end else begin
            bus_state_next = ctci_pkg::CTCI_BUS_RDWAIT;
            hready_next    = 1'b0;
          end
        end
      end
      ctci_pkg::CTCI_BUS_RDWAIT: begin
        hrdata_next    = rd_value;
        hready_next    = 1'b1;
        bus_state_next = ctci_pkg::CTCI_BUS_IDLE;
      end
      default: begin
        bus_state_next = ctci_pkg::CTCI_BUS_IDLE;
        hready_next    = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= ctci_pkg::CTCI_BUS_IDLE;
      dp_write_reg  <= 1'b0;
      dp_addr_reg   <= 8'h00;
      dp_be_reg     <= 4'h0;
      hrdata_reg    <= 32'h00000000;
      hready_reg    <= 1'b1;
    end else begin
      bus_state_reg <= bus_state_next;
      dp_write_reg  <= dp_write_next;
      dp_addr_reg   <= dp_addr_next;
      dp_be_reg     <= dp_be_next;
      hrdata_reg    <= hrdata_next;
      hready_reg    <= hready_next;
    end
  end

  logic [31:0] wmask;  // byte-lane write mask of the data phase
  logic        wr_cfg0;
  logic        wr_int;
  logic        wr_cfg1;

  assign wmask   = {{8{dp_be_reg[3]}}, {8{dp_be_reg[2]}}, {8{dp_be_reg[1]}}, {8{dp_be_reg[0]}}};
  assign wr_cfg0 = dp_write_reg & (dp_addr_reg == ctci_pkg::CFG0_OFFSET);
  assign wr_int  = dp_write_reg & (dp_addr_reg == ctci_pkg::INT_OFFSET);
  assign wr_cfg1 = dp_write_reg & (dp_addr_reg == ctci_pkg::CFG1_OFFSET);

  // ----------------------------------------------------------------
  // configuration and switch state
  // ----------------------------------------------------------------
  logic [31:0] cfg0_reg, cfg0_next;      // writable fields, status bits zero
  logic [3:0]  prediv_reg, prediv_next;  // pll_prediv0, bit 0 shared
  logic [1:0]  stat_reg, stat_next;      // sysclk_switch_status
  logic [31:0] cfg0_view;                // readable image of clock_config_0
  logic [31:0] cfg0_wr;                  // merged write value
  logic [1:0]  req_src;                  // requested source
  logic        xtal_in_use;              // crystal feeds system clock
  logic        req_ready;                // requested source stable

  always_comb begin
    cfg0_view = cfg0_reg;
    cfg0_view[ctci_pkg::PREDIV_BIT] = prediv_reg[0];
    cfg0_view[ctci_pkg::STAT_LSB +: 2] = stat_reg;
  end

  assign cfg0_wr = (cfg0_view & ~wmask) | (hwdata & wmask);
  assign req_src = cfg0_reg[ctci_pkg::REQ_LSB +: 2];

  // a dead crystal matters only while it feeds the system clock
  assign xtal_in_use = (stat_reg == ctci_pkg::SRC_XTAL) ||
                       ((stat_reg == ctci_pkg::SRC_PLL) && cfg0_reg[ctci_pkg::PLL_SRC_BIT]);

  // flag order: 2 internal 8m osc, 3 crystal, 4 pll
  always_comb begin
    case (req_src)
      ctci_pkg::SRC_INT8M: req_ready = osc_ready[2];
      ctci_pkg::SRC_XTAL:  req_ready = osc_ready[3];
      ctci_pkg::SRC_PLL:   req_ready = osc_ready[4];
      default:             req_ready = 1'b0;  // reserved code never taken
    endcase
  end

  always_comb begin
    cfg0_next   = cfg0_reg;
    prediv_next = prediv_reg;
    stat_next   = stat_reg;
    if (wr_cfg0) begin
      // bits 31:30 reserved; status and shared bit kept apart
      cfg0_next = cfg0_wr & 32'h3FFCFFF3;
      cfg0_next[ctci_pkg::PLL_SRC_BIT] = cfg0_wr[ctci_pkg::PLL_SRC_BIT];
      if (usb_on) begin
        cfg0_next[ctci_pkg::USB_LSB +: 2] = cfg0_reg[ctci_pkg::USB_LSB +: 2];
      end
      prediv_next[0] = cfg0_wr[ctci_pkg::PREDIV_BIT];
    end
    if (wr_cfg1) begin
      prediv_next = (prediv_reg & ~wmask[3:0]) | (hwdata[3:0] & wmask[3:0]);
    end
    if (req_src != stat_reg && req_ready) begin
      stat_next = req_src;
    end
    if (wake_rise || (stuck_rise && xtal_in_use)) begin
      cfg0_next[ctci_pkg::REQ_LSB +: 2] = ctci_pkg::SRC_INT8M;
      stat_next = ctci_pkg::SRC_INT8M;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg0_reg   <= ctci_pkg::CFG0_RESET;
      prediv_reg <= ctci_pkg::CFG1_PREDIV_RESET;
      stat_reg   <= ctci_pkg::SRC_INT8M;
    end else begin
      cfg0_reg   <= cfg0_next;
      prediv_reg <= prediv_next;
      stat_reg   <= stat_next;
    end
  end

  // ----------------------------------------------------------------
  // clock interrupt register
  // ----------------------------------------------------------------
  logic [6:0] irq_en_reg, irq_en_next;  // enables 14:8
  logic [7:0] flag_reg,   flag_next;    // flags 7:0
  logic [7:0] clr_hit;                  // write-one clears this cycle
  logic [7:0] set_hit;                  // hardware set events

  assign clr_hit = wr_int ? (hwdata[ctci_pkg::INT_CLR_LSB +: 8] & wmask[23:16]) : 8'h00;
  // stuck crystal sets flag, no enable
  assign set_hit = {stuck_rise, osc_rise & irq_en_reg};

  // set wins over a clear landing in the same cycle
  always_comb begin
    irq_en_next = irq_en_reg;
    if (wr_int) begin
      irq_en_next = (irq_en_reg & ~wmask[14:8]) | (hwdata[14:8] & wmask[14:8]);
    end
    flag_next = (flag_reg & ~clr_hit) | set_hit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_reg <= ctci_pkg::INT_RESET[14:8];
      flag_reg   <= ctci_pkg::INT_RESET[7:0];
    end else begin
      irq_en_reg <= irq_en_next;
      flag_reg   <= flag_next;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // clear bits and reserved bits read as zero; unmapped reads zero
  always_comb begin
    case (dp_addr_reg)
      ctci_pkg::CFG0_OFFSET: rd_value = cfg0_view;
      ctci_pkg::INT_OFFSET:  rd_value = {17'h00000, irq_en_reg, flag_reg};
      ctci_pkg::CFG1_OFFSET: rd_value = {28'h0000000, prediv_reg};
      default:               rd_value = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // registered clock tree controls
  // ----------------------------------------------------------------
  logic [3:0] ckout_code;  // raw clock_out_source_sel
  logic [4:0] mf_code;     // reassembled pll_mult_factor
  logic [2:0] adc_code;    // reassembled adc_clock_prescale
  logic [4:0] prediv_dec;

  assign ckout_code = cfg0_reg[ctci_pkg::CKOUT_LSB +: 4];
  assign mf_code  = {cfg0_reg[ctci_pkg::MF_HI_BIT], cfg0_reg[ctci_pkg::MF_LO_LSB +: 4]};
  assign adc_code = {cfg0_reg[ctci_pkg::ADC_HI_BIT], cfg0_reg[ctci_pkg::ADC_LO_LSB +: 2]};

  // low bit alone when upper bits clear
  always_comb begin
    if (prediv_reg[3:1] == 3'h0) begin
      prediv_dec = prediv_reg[0] ? 5'h02 : 5'h01;
    end else begin
      prediv_dec = 5'({1'b0, prediv_reg} + 5'h01);
    end
  end

  // outputs lag the fields by one clock, which glitch-free muxes tolerate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_out_mux_sel <= 4'h0;
      usb_div_x2        <= 3'h3;
      pll_mult_x2       <= 7'h04;
      pll_source_sel    <= 1'b0;
      prediv0_div       <= 5'h01;
      adc_div           <= 5'h02;
      apb2_div          <= 5'h01;
      apb1_div          <= 5'h01;
      ahb_div           <= 10'h001;
      sysclk_mux_sel    <= ctci_pkg::SRC_INT8M;
      clock_irq         <= 1'b0;
      clock_nmi         <= 1'b0;
    end else begin
      // 00xx and undefined codes give none
      clock_out_mux_sel <= (ckout_code[3:2] != 2'h0 && ckout_code <= 4'hB) ? ckout_code : 4'h0;
      usb_div_x2        <= usb_x2(cfg0_reg[ctci_pkg::USB_LSB +: 2]);
      pll_mult_x2       <= mult_x2(mf_code);
      pll_source_sel    <= cfg0_reg[ctci_pkg::PLL_SRC_BIT];
      prediv0_div       <= prediv_dec;
      adc_div           <= adc_dec(adc_code);
      apb2_div          <= apb_dec(cfg0_reg[ctci_pkg::APB2_LSB +: 3]);
      apb1_div          <= apb_dec(cfg0_reg[ctci_pkg::APB1_LSB +: 3]);
      ahb_div           <= ahb_dec(cfg0_reg[ctci_pkg::AHB_LSB +: 4]);
      sysclk_mux_sel    <= stat_reg;
      clock_irq         <= |flag_reg[6:0];
      clock_nmi         <= flag_reg[ctci_pkg::STUCK_BIT];
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp     = 1'b0;  // always okay

endmodule

// File: testbench/ctci_chk.sv
// ctci_chk: bus timing and clock-tree code checks on ctci_top ports
// assumes hready at the top is the slave's own hreadyout
`timescale 1ns/100ps
module ctci_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [6:0] osc_stable_async,
  input wire logic       xtal_stuck_async,
  input wire logic       wake_async,
  input wire logic [1:0] sysclk_mux_sel,
  input wire logic [3:0] clock_out_mux_sel,
  input wire logic [2:0] usb_div_x2,
  input wire logic       clock_nmi
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic take;  // address phase accepted this edge
  assign take = hsel & htrans[1] & hready;
  // one wait state, then data
  sequence read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // target source ready at the pin when the switch lands
  sequence src_ready;
    (sysclk_mux_sel == 2'h1 && osc_stable_async[3]) ||
    (sysclk_mux_sel == 2'h2 && osc_stable_async[4]);
  endsequence
  chk_resp_okay:
    assert property (hresp == 1'b0) else $error("response not okay");
  chk_read_wait:
    assert property (take && !hwrite |-> ##1 read_wait) else $error("read wait wrong");
  chk_write_nowait:
    assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  chk_status_code:
    assert property (sysclk_mux_sel != 2'h3) else $error("reserved clock source");
  chk_switch_ready:
    assert property ($changed(sysclk_mux_sel) && sysclk_mux_sel != 2'h0 |-> src_ready)
      else $error("switched before source ready");
  chk_wake_force:
    assert property ($rose(wake_async) |-> ##[1:10] sysclk_mux_sel == 2'h0)
      else $error("wake did not force internal source");
  chk_stuck_nmi:
    assert property ($rose(xtal_stuck_async) |-> ##[1:10] clock_nmi)
      else $error("stuck crystal gave no nmi");
  chk_ckout_code:
    assert property (clock_out_mux_sel == 4'h0 || clock_out_mux_sel inside {[4'h4:4'hB]})
      else $error("clock-out code out of range");
  chk_usb_ratio:
    assert property (usb_div_x2 inside {3'h2, 3'h3, 3'h4, 3'h5}) else $error("usb ratio bad");
endmodule
bind ctci_top ctci_chk ctci_chk_inst (.*);

// File: testbench/clock_tree_config_and_irq_tb.sv
// clock_tree_config_and_irq_tb: register-level tests of ctci_top
// assumes one ahb-lite master here, hready looped from hreadyout
`timescale 1ns/100ps
module clock_tree_config_and_irq_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        xtal_stuck_async, usb_clk_en_async, wake_async;
  logic        pll_source_sel, clock_irq, clock_nmi;
  logic [31:0] haddr, hwdata, hrdata, r, v;
  logic [1:0]  htrans, sysclk_mux_sel;
  logic [2:0]  hsize, usb_div_x2;
  logic [3:0]  clock_out_mux_sel;
  logic [4:0]  prediv0_div, adc_div, apb2_div, apb1_div, c;
  logic [6:0]  pll_mult_x2;
  logic [6:0]  osc_stable_async;
  logic [9:0]  ahb_div;
  int          num_errors, comparisons;
  wire         hready = hreadyout;  // the only slave drives bus ready
  // expected ratios, indexed by field code
  logic [2:0]  usb_t [4] = '{3'h3, 3'h2, 3'h5, 3'h4};
  logic [4:0]  adc_t [8] = '{5'h02, 5'h04, 5'h06, 5'h08, 5'h02, 5'h0C, 5'h08, 5'h10};
  ctci_top ctci_top_inst (.*);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task chk(input string n, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // single transfer: each phase held until ready is sampled high
  task bus(input logic w, input logic [31:0] a, d, input logic [2:0] s);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [31:0] a, d);
    bus(1'b1, a, d, 3'h2);
  endtask
  task rd(input string n, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0, 3'h2);
    chk(n, r, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // pll multiplier times two, from the field code
  function automatic logic [6:0] mf2(input logic [4:0] k);
    if (k < 5'h0D) return 7'(2 * k + 4);
    if (k == 5'h0D) return 7'h0D;
    if (k < 5'h10) return 7'h20;
    return 7'(2 * k + 2);
  endfunction
  task final_report;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    wt(6000);
    num_errors++;
    final_report;
  end
  initial begin
    {hresetn, hsel, hwrite, xtal_stuck_async, usb_clk_en_async, wake_async} = 6'h00;
    {haddr, hwdata, htrans, hsize, osc_stable_async} = 76'h0;
    wt(12);
    hresetn <= 1'b1;
    wt(1);
    rd("cfg0", 32'h04, 32'h0);
    rd("int", 32'h08, 32'h0);
    chk("prediv", prediv0_div, 5'h01);
    $display("reset values done");
    // every code of each clock tree field of the config word, switch request left at 0, several fields per pass
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      v = {2'h0, c[4], c[2], c[3:0], c[1:0], c[3:0], c[0], c[1],
           c[1:0], c[2:0], c[2:0], c[3:0], 4'h0};
      wr(32'h04, v);
      wt(2);
      chk("ckout", clock_out_mux_sel, c[3:0] inside {[4'h4:4'hB]} ? c[3:0] : 4'h0);
      chk("usb", usb_div_x2, usb_t[c[1:0]]);
      chk("mult", pll_mult_x2, mf2(c));
      chk("src", pll_source_sel, c[1]);
      chk("prediv", prediv0_div, c[0] ? 5'h02 : 5'h01);
      chk("adc", adc_div, adc_t[c[2:0]]);
      chk("apb2", apb2_div, c[2] ? 5'h02 << c[1:0] : 5'h01);
      chk("apb1", apb1_div, c[2] ? 5'h02 << c[1:0] : 5'h01);
      chk("ahb", ahb_div, c[3] ? 10'h002 << (c[1:0] + (c[2] ? 4'h5 : 4'h0)) : 10'h001);
      rd("cfg0 back", 32'h04, v);
    end
    $display("field tables done");
    wr(32'h04, 32'h00010002);
    wt(12);
    rd("status wait", 32'h04, 32'h00010002);
    wr(32'h08, 32'h00003F00);
    osc_stable_async <= 7'h7F;
    wt(12);
    rd("flags set", 32'h08, 32'h00003F3F);
    rd("status pll", 32'h04, 32'h0001000A);
    chk("mux pll", sysclk_mux_sel, 2'h2);
    chk("irq on", clock_irq, 1'b1);
    wr(32'h08, 32'h00013F00);
    wt(3);
    rd("one clear", 32'h08, 32'h00003F3E);
    chk("irq held", clock_irq, 1'b1);
    wr(32'h08, 32'h007E3F00);
    wt(3);
    rd("all clear", 32'h08, 32'h00003F00);
    chk("irq off", clock_irq, 1'b0);
    $display("flags done");
    xtal_stuck_async <= 1'b1;
    wt(12);
    chk("mux fail", sysclk_mux_sel, 2'h0);
    chk("nmi on", clock_nmi, 1'b1);
    rd("cfg0 fail", 32'h04, 32'h00010000);
    rd("stuck flag", 32'h08, 32'h00003F80);
    xtal_stuck_async <= 1'b0;
    wr(32'h08, 32'h00803F00);
    wt(3);
    chk("nmi off", clock_nmi, 1'b0);
    wr(32'h04, 32'h00000001);
    wt(12);
    chk("mux xtal", sysclk_mux_sel, 2'h1);
    wake_async <= 1'b1;
    wt(12);
    rd("cfg0 wake", 32'h04, 32'h0);
    wake_async <= 1'b0;
    $display("switch done");
    usb_clk_en_async <= 1'b1;
    wt(12);
    wr(32'h04, 32'h00C00000);
    wt(2);
    chk("usb locked", usb_div_x2, 3'h3);
    usb_clk_en_async <= 1'b0;
    wt(12);
    wr(32'h04, 32'h00C00000);
    wt(2);
    chk("usb free", usb_div_x2, 3'h4);
    wr(32'h2C, 32'h1);
    wt(2);
    rd("shared bit", 32'h04, 32'h00C20000);
    chk("div2", prediv0_div, 5'h02);
    wr(32'h2C, 32'h5);
    wt(2);
    chk("prediv5", prediv0_div, 5'h06);
    wr(32'h04, 32'h00C00000);
    rd("cfg1 view", 32'h2C, 32'h4);
    wr(32'h08, 32'h00004000);
    rd("pll2 enable", 32'h08, 32'h00004000);
    osc_stable_async <= 7'h3F;
    wt(8);
    osc_stable_async <= 7'h7F;
    wt(12);
    rd("pll2 flag", 32'h08, 32'h00004040);
    chk("irq pll2", clock_irq, 1'b1);
    rd("unmapped", 32'h10, 32'h0);
    $display("access done");
    final_report;
  end
endmodule
